/* File: core/afs_pkg.sv */
// Package with register map, field layout and reset values of the status logic.
package afs_pkg;

  // Register indices on the serial register port.
  localparam logic [3:0]  AFS_ADDR_TOP_STATUS = 4'h0;
  localparam logic [3:0]  AFS_ADDR_FAULT_MASK = 4'h6;

  // Field positions inside the top status register.
  localparam int          AFS_BIT_SUMMARY     = 0;
  localparam int          AFS_BIT_OVERTEMP    = 2;
  localparam int          AFS_BIT_SHUTDOWN    = 3;
  localparam int          AFS_BIT_CHECKSUM    = 4;
  localparam int          AFS_BIT_CHANNEL     = 5;
  localparam int          AFS_REV_LSB         = 8;

  // Field positions inside the fault mask register.
  localparam int          AFS_MASK_CH_LSB     = 0;
  localparam int          AFS_MASK_SD_BIT     = 8;
  localparam int          AFS_MASK_OT_BIT     = 9;

  // Widths and reset values.
  localparam int          AFS_DATA_W          = 16;
  localparam int          AFS_REV_W           = 8;
  localparam logic [15:0] AFS_MASK_RESET      = 16'h0000;
  localparam logic [15:0] AFS_WORD_ZERO       = 16'h0000;

  // Revision code; the value is arbitrary.
  localparam logic [7:0]  AFS_REV_DEFAULT     = 8'h01;

  // Indices of the sticky fault flags.
  localparam int          AFS_NUM_FLAGS       = 4;
  localparam int          AFS_FLG_OT          = 0;
  localparam int          AFS_FLG_SD          = 1;
  localparam int          AFS_FLG_CRC         = 2;
  localparam int          AFS_FLG_CH          = 3;

endpackage

/* File: core/afs_status_logic.sv */
// Top status, fault latching, masking and error pin of the front end.
`timescale 1ns/1ns
module afs_status_logic
  import afs_pkg::*;
#(
  parameter int         CH_FAULTS = 8,              // Channel conditions.
  parameter logic [7:0] REV_CODE  = AFS_REV_DEFAULT // Arbitrary revision.
)
(
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // Register read port from the serial interface.
  input  wire logic                  rd_strobe,
  input  wire logic [3:0]            rd_addr,
  output logic [AFS_DATA_W-1:0]      rd_data,
  output logic                       rd_valid,
  // Register write port from the serial interface.
  input  wire logic                  wr_strobe,
  input  wire logic [3:0]            wr_addr,
  input  wire logic [AFS_DATA_W-1:0] wr_data,
  input  wire logic                  wr_crc_bad,
  // Live fault conditions from the analog side.
  input  wire logic [CH_FAULTS-1:0]  chan_fault,
  input  wire logic                  thermal_sd,
  input  wire logic                  overtemp,
  // Open-drain error pin, low output enable while driving.
  output logic                       err_pin_out,
  output logic                       err_pin_oe_n,
  // Forced power-down controls.
  output logic                       force_vmode,
  output logic                       isrc_off,
  output logic                       fldpwr_off,
  output logic                       pga_part_off
);

  // Refuse channel widths that do not fit below the temperature mask bits.
  if (CH_FAULTS < 1 || CH_FAULTS > AFS_MASK_SD_BIT)
  begin : g_bad_width
    $error("CH_FAULTS must lie between 1 and 8");
  end

  // Address decode shared by the read and write paths.
  function automatic logic is_addr(input logic [3:0] a,
                                   input logic [3:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  logic [AFS_DATA_W-1:0]    mask_reg;      // Fault mask register.
  logic [AFS_DATA_W-1:0]    mask_next;     // Next mask value.
  logic                     summary_reg;   // Registered summary bit.
  logic                     summary_next;  // Next summary bit.
  logic [AFS_DATA_W-1:0]    rd_data_reg;   // Captured read word.
  logic [AFS_DATA_W-1:0]    rd_data_next;  // Next read word.
  logic                     rd_valid_reg;  // Read answer strobe.
  logic                     rd_valid_next; // Next read answer strobe.
  logic                     rd_status;     // Read of the status register.
  logic [AFS_NUM_FLAGS-1:0] flag_set;      // Set terms of the flags.
  logic [AFS_NUM_FLAGS-1:0] flags;         // Latched flags.
  logic [CH_FAULTS-1:0]     ch_mask;       // Channel mask slice.
  logic [AFS_DATA_W-1:0]    status_word;   // Assembled status word.

  assign rd_status = rd_strobe & is_addr(rd_addr, AFS_ADDR_TOP_STATUS);
  assign ch_mask   = mask_reg[AFS_MASK_CH_LSB +: CH_FAULTS];

  // Set terms: flags latch the raw conditions, regardless of the mask.
  always_comb
  begin
    flag_set             = '0;
    flag_set[AFS_FLG_OT]  = overtemp;
    flag_set[AFS_FLG_SD]  = thermal_sd;
    flag_set[AFS_FLG_CRC] = wr_strobe & wr_crc_bad;
    flag_set[AFS_FLG_CH]  = |chan_fault;
  end

  // One sticky latch per fault flag, cleared by a status read.
  for (genvar i = 0; i < AFS_NUM_FLAGS; i++)
  begin : g_flag
    afs_sticky_flag u_flag
    (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .set_in   (flag_set[i]),
      .clear_in (rd_status),
      .flag_out (flags[i])
    );
  end

  // Mask register writes; a write that fails its checksum is dropped.
  always_comb
  begin
    mask_next = mask_reg;
    if (wr_strobe && !wr_crc_bad &&
        is_addr(wr_addr, AFS_ADDR_FAULT_MASK))
    begin
      mask_next = wr_data;
    end
  end

  // Live summary: OR of unmasked conditions, independent of reads.
  always_comb
  begin
    summary_next = (|(chan_fault & ~ch_mask)) |
                   (thermal_sd & ~mask_reg[AFS_MASK_SD_BIT]) |
                   (overtemp   & ~mask_reg[AFS_MASK_OT_BIT]);
  end

  // Status word layout with revision byte and zero reserved bits.
  always_comb
  begin
    status_word                   = AFS_WORD_ZERO;
    status_word[AFS_REV_LSB +: AFS_REV_W] = REV_CODE;
    status_word[AFS_BIT_CHANNEL]  = flags[AFS_FLG_CH];
    status_word[AFS_BIT_CHECKSUM] = flags[AFS_FLG_CRC];
    status_word[AFS_BIT_SHUTDOWN] = flags[AFS_FLG_SD];
    status_word[AFS_BIT_OVERTEMP] = flags[AFS_FLG_OT];
    status_word[AFS_BIT_SUMMARY]  = summary_reg;
  end

  // Read mux; the port answers in every thermal state.
  always_comb
  begin
    rd_valid_next = rd_strobe;
    rd_data_next  = rd_data_reg;
    if (rd_strobe)
    begin
      if (rd_status)
      begin
        rd_data_next = status_word;
      end
      else if (is_addr(rd_addr, AFS_ADDR_FAULT_MASK))
      begin
        rd_data_next = mask_reg;
      end
      else
      begin
        rd_data_next = AFS_WORD_ZERO;  // Unmapped reads return zero.
      end
    end
  end

  // Register all control and answer state.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_reg     <= AFS_MASK_RESET;
      summary_reg  <= 1'b0;
      rd_data_reg  <= AFS_WORD_ZERO;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      mask_reg     <= mask_next;
      summary_reg  <= summary_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // Open drain: the level is always low, the enable follows the summary.
  assign err_pin_out  = 1'b0;
  assign err_pin_oe_n = ~summary_reg;

  // Power-down forcing during thermal shutdown.
  afs_thermal_guard u_guard
  (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .shutdown_in  (thermal_sd),
    .force_vmode  (force_vmode),
    .isrc_off     (isrc_off),
    .fldpwr_off   (fldpwr_off),
    .pga_part_off (pga_part_off)
  );

  // Steps of a status read and of a rejected write.
  sequence seq_rd_status;
    rd_strobe && rd_addr == AFS_ADDR_TOP_STATUS;
  endsequence

  sequence seq_bad_write;
    wr_strobe && wr_crc_bad;
  endsequence

  // A held flag stays set while no status read happens.
  AST_STICKY_HOLD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    flags[AFS_FLG_CH] && !rd_status |=> flags[AFS_FLG_CH])
    else $error("Channel flag dropped without a status read.");

  // A status read with no new event clears the flag.
  AST_READ_CLEAR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seq_rd_status ##0 !overtemp |=> !flags[AFS_FLG_OT])
    else $error("Overtemperature flag survived a status read.");

  // An unmasked channel fault raises the summary next cycle.
  AST_SUMMARY_LIVE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (|(chan_fault & ~ch_mask)) |=> summary_reg)
    else $error("Summary missed an unmasked channel fault.");

  // A read while a live unmasked fault stands keeps the summary set.
  AST_READ_KEEPS_SUMMARY: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seq_rd_status ##0 (|(chan_fault & ~ch_mask))
    |=> summary_reg)
    else $error("Status read disturbed the summary bit.");

  // Fully masked sources cannot raise the summary.
  AST_MASK_BLOCKS: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (&ch_mask) && mask_reg[AFS_MASK_SD_BIT] && mask_reg[AFS_MASK_OT_BIT]
    |=> !summary_reg)
    else $error("Masked fault reached the summary bit.");

  // A failed write latches the checksum flag and leaves the mask alone.
  AST_CRC_FLAG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seq_bad_write |=> flags[AFS_FLG_CRC] && $stable(mask_reg))
    else $error("Checksum failure not handled.");

  // A channel fault is latched on the next edge.
  AST_CH_FLAG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (|chan_fault) |=> flags[AFS_FLG_CH])
    else $error("Channel fault not latched.");

  // Shutdown sets its flag and all forcing controls together.
  AST_SHUTDOWN_FORCE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    thermal_sd |=> flags[AFS_FLG_SD] && force_vmode && isrc_off &&
                   fldpwr_off && pga_part_off)
    else $error("Shutdown actions missing.");

  // Reads still answer during shutdown.
  AST_SD_READ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    thermal_sd && rd_strobe |=> rd_valid)
    else $error("Register read lost during shutdown.");

  // Overtemperature warning is latched on the next edge.
  AST_OT_FLAG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    overtemp |=> flags[AFS_FLG_OT])
    else $error("Overtemperature warning not latched.");

  // The pin is driven low exactly while the summary is set.
  AST_PIN: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    summary_reg |-> !err_pin_oe_n && !err_pin_out)
    else $error("Error pin not driven for a set summary.");

  // A status read answers with revision and zero reserved bits.
  AST_STATUS_LAYOUT: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seq_rd_status |=> rd_valid && rd_data[7:6] == 2'b00 &&
                      !rd_data[1] && rd_data[15:8] == REV_CODE)
    else $error("Status word layout wrong.");

  // Steps of a mask write that passed its checksum.
  sequence seq_good_mask_write;
    wr_strobe && !wr_crc_bad && wr_addr == AFS_ADDR_FAULT_MASK;
  endsequence

  // A clean mask write lands in the mask on the next edge.
  AST_MASK_WRITE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seq_good_mask_write |=> mask_reg == $past(wr_data))
    else $error("Mask write did not land.");

  // With no unmasked condition the summary drops on the next edge.
  AST_SUMMARY_CLEAR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(|(chan_fault & ~ch_mask)) &&
    !(thermal_sd && !mask_reg[AFS_MASK_SD_BIT]) &&
    !(overtemp && !mask_reg[AFS_MASK_OT_BIT])
    |=> !summary_reg)
    else $error("Summary stayed set without an unmasked fault.");

  // The pin is released while the summary is clear.
  AST_PIN_RELEASE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !summary_reg |-> err_pin_oe_n)
    else $error("Error pin driven for a clear summary.");

  // The forcing controls drop one cycle after shutdown ends.
  AST_SD_RELEASE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !thermal_sd |=> !force_vmode && !isrc_off &&
                    !fldpwr_off && !pga_part_off)
    else $error("Forcing controls held after shutdown ended.");

endmodule // afs_status_logic

/* File: core/afs_sticky_flag.sv */
// Single sticky fault flag where a new event beats a clearing read.
`timescale 1ns/1ns
module afs_sticky_flag
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Event and clear.
  input  wire logic set_in,
  input  wire logic clear_in,
  // Latched flag.
  output logic      flag_out
);

  logic flag_reg;   // Held flag.
  logic flag_next;  // Next flag value.

  // The set term is ORed last, so an event in the clearing cycle survives.
  always_comb
  begin
    flag_next = set_in | (flag_reg & ~clear_in);
  end

  // Register the flag.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule // afs_sticky_flag

/* File: core/afs_thermal_guard.sv */
// Forced power-down controls applied while the die is in thermal shutdown.
`timescale 1ns/1ns
module afs_thermal_guard
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Live shutdown condition.
  input  wire logic shutdown_in,
  // Forced controls to the analog blocks.
  output logic      force_vmode,
  output logic      isrc_off,
  output logic      fldpwr_off,
  output logic      pga_part_off
);

  logic [3:0] force_reg;   // Registered forcing controls.
  logic [3:0] force_next;  // Next forcing controls.

  // All four power-saving actions follow the shutdown level together.
  always_comb
  begin
    force_next = {4{shutdown_in}};
  end

  // Register the controls so the outputs are glitch free.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      force_reg <= 4'h0;
    end
    else
    begin
      force_reg <= force_next;
    end
  end

  assign force_vmode  = force_reg[0];
  assign isrc_off     = force_reg[1];
  assign fldpwr_off   = force_reg[2];
  assign pga_part_off = force_reg[3];

endmodule // afs_thermal_guard

/* File: tb/afs_host_model.sv */
// Host controller model that issues register reads and writes.
`timescale 1ns/1ns
module afs_host_model
(
  // Clock.
  input  wire logic        core_clk,
  // Read port.
  output logic             rd_strobe,
  output logic [3:0]       rd_addr,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  // Write port.
  output logic             wr_strobe,
  output logic [3:0]       wr_addr,
  output logic [15:0]      wr_data,
  output logic             wr_crc_bad
);
  // Idle levels at time zero; no request is pending.
  initial
  begin
    rd_strobe  = 1'b0;
    rd_addr    = 4'hf;
    wr_strobe  = 1'b0;
    wr_addr    = 4'hf;
    wr_data    = 16'hffff;
    wr_crc_bad = 1'b0;
  end

  // One read pulse; the answer must stand exactly one cycle after the edge.
  // After the pulse the address is inverted so a stale value is never used.
  task automatic read_reg(input logic [3:0] addr, output logic [15:0] data);
    @(negedge core_clk);
    rd_strobe = 1'b1;
    rd_addr   = addr;
    @(negedge core_clk);
    rd_strobe = 1'b0;
    rd_addr   = ~addr;
    data = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
  endtask

  // One write pulse; a bad checksum is sent only when the caller asks.
  // Checksum protection is taken as enabled with code 10 on the link.
  task automatic write_reg(input logic [3:0] addr, input logic [15:0] data,
                           input logic bad);
    @(negedge core_clk);
    wr_strobe  = 1'b1;
    wr_addr    = addr;
    wr_data    = data;
    wr_crc_bad = bad;
    @(negedge core_clk);
    wr_strobe  = 1'b0;
    wr_addr    = ~addr;
    wr_data    = ~data;
    wr_crc_bad = 1'b0;
  endtask
endmodule // afs_host_model

/* File: tb/tb_top.sv */
// Self-checking testbench of the front-end status logic.
`timescale 1ns/1ns
module tb_top
  import afs_pkg::*;
;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision for the run.

  logic        core_clk  = 1'b0;     // Core clock.
  logic        reset_n   = 1'b0;     // Active-low reset.
  logic        rd_strobe, rd_valid, wr_strobe, wr_crc_bad;
  logic [3:0]  rd_addr, wr_addr;
  logic [15:0] rd_data, wr_data;
  logic [7:0]  chan_fault;           // Live channel conditions.
  logic        thermal_sd, overtemp; // Live thermal conditions.
  logic        err_pin_out, err_pin_oe_n;
  logic        force_vmode, isrc_off, fldpwr_off, pga_part_off;
  logic        err_wire;             // Error pin level with pull-up.
  int          error_cnt = 0;
  int          tests_run = 0;

  // The pin is pulled up unless the design drives it.
  assign err_wire = (err_pin_oe_n === 1'b0) ? err_pin_out : 1'b1;

  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;

  afs_status_logic #(.CH_FAULTS(8), .REV_CODE(REV)) afs_status_logic_i (
    .core_clk(core_clk), .reset_n(reset_n), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_crc_bad(wr_crc_bad), .chan_fault(chan_fault),
    .thermal_sd(thermal_sd), .overtemp(overtemp),
    .err_pin_out(err_pin_out), .err_pin_oe_n(err_pin_oe_n),
    .force_vmode(force_vmode), .isrc_off(isrc_off),
    .fldpwr_off(fldpwr_off), .pga_part_off(pga_part_off));

  afs_host_model afs_host_model_i (
    .core_clk(core_clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_crc_bad(wr_crc_bad));

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Waits the given number of falling edges.
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Expected status word from the flag values.
  function automatic logic [15:0] st(logic ch, logic crc, logic sd,
                                     logic ot, logic sum);
    return {REV, 2'b00, ch, crc, sd, ot, 1'b0, sum};
  endfunction

  // Packs the forced power-down controls.
  function automatic logic [15:0] forced();
    return {12'h000, force_vmode, isrc_off, fldpwr_off, pga_part_off};
  endfunction

  // Values right after reset.
  task automatic t_reset();
    logic [15:0] d;
    check({15'h0, err_wire}, 16'h0001, "pin after reset");
    check(forced(), 16'h0000, "forcing after reset");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(0, 0, 0, 0, 0), "status after reset");
    afs_host_model_i.read_reg(AFS_ADDR_FAULT_MASK, d);
    check(d, AFS_MASK_RESET, "mask after reset");
  endtask

  // A one-cycle warning is captured and cleared by a read.
  task automatic t_sticky();
    logic [15:0] d;
    overtemp = 1'b1;
    idle(1);
    // The host lowers dissipation, so the warning goes away.
    overtemp = 1'b0;
    idle(2);
    check({15'h0, err_wire}, 16'h0001, "pin after pulse");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(0, 0, 0, 1, 0), "warning latched");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(0, 0, 0, 0, 0), "warning cleared");
  endtask

  // Each channel condition drives the pin and is masked by its own bit.
  task automatic t_channel();
    logic [15:0] d;
    for (int i = 0; i < 8; i++)
    begin
      chan_fault = 8'h01 << i;
      idle(2);
      check({15'h0, err_wire}, 16'h0000, "pin on fault");
      afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
      afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
      check(d, st(1, 0, 0, 0, 1), "read keeps summary");
      afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, 16'h0001 << i, 1'b0);
      idle(2);
      check({15'h0, err_wire}, 16'h0001, "mask frees pin");
      chan_fault = 8'h00;
      afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, AFS_MASK_RESET, 1'b0);
      afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
      check(d, st(1, 0, 0, 0, 0), "flag held to read");
    end
  endtask

  // Bad-checksum write is dropped and latched; odd writes and reads.
  task automatic t_checksum();
    logic [15:0] d;
    afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, 16'hffff, 1'b1);
    afs_host_model_i.write_reg(AFS_ADDR_TOP_STATUS, 16'h00ff, 1'b0);
    afs_host_model_i.read_reg(AFS_ADDR_FAULT_MASK, d);
    check(d, AFS_MASK_RESET, "bad write dropped");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(0, 1, 0, 0, 0), "checksum flag");
    afs_host_model_i.read_reg(4'h3, d);
    check(d, AFS_WORD_ZERO, "unmapped read");
  endtask

  // Every source masked at once: the pin stays free, flags still latch.
  task automatic t_mask_all();
    logic [15:0] d;
    afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, 16'h03ff, 1'b0);
    chan_fault = 8'hff;
    overtemp   = 1'b1;
    thermal_sd = 1'b1;
    idle(2);
    check({15'h0, err_wire}, 16'h0001, "all masked");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(1, 0, 1, 1, 0), "masked faults latched");
    chan_fault = 8'h00;
    overtemp   = 1'b0;
    thermal_sd = 1'b0;
    afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, AFS_MASK_RESET, 1'b0);
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(1, 0, 1, 1, 0), "masked flags held");
    check({15'h0, err_wire}, 16'h0001, "pin free after");
  endtask

  // Shutdown forces power-down while the register port keeps working.
  task automatic t_thermal();
    logic [15:0] d;
    thermal_sd = 1'b1;
    idle(2);
    check(forced(), 16'h000f, "forced off");
    check({15'h0, err_wire}, 16'h0000, "pin in shutdown");
    afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, 16'h0100, 1'b0);
    idle(2);
    afs_host_model_i.read_reg(AFS_ADDR_FAULT_MASK, d);
    check(d, 16'h0100, "port alive");
    afs_host_model_i.read_reg(AFS_ADDR_TOP_STATUS, d);
    check(d, st(0, 0, 1, 0, 0), "shutdown masked");
    thermal_sd = 1'b0;
    afs_host_model_i.write_reg(AFS_ADDR_FAULT_MASK, AFS_MASK_RESET, 1'b0);
    check(forced(), 16'h0000, "forcing released");
  endtask

  // Main sequence.
  initial
  begin
    chan_fault = 8'h00;
    thermal_sd = 1'b0;
    overtemp   = 1'b0;
    idle(5);
    reset_n = 1'b1;
    t_reset();
    t_sticky();
    t_channel();
    t_checksum();
    t_thermal();
    t_mask_all();
    tally_and_finish();
  end

  // Watchdog well beyond the 160 cycles the tests need.
  initial
  begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_top
